// >>> verilog/sfs_sequencer.sv
`timescale 1ns/1ns
// Contract
// - wait 64 cycles, then ramp per cycle
// - ramp takes 1280 cycles per volt
// - pwm high-impedance until reference reaches output
// - 100mV sense offset ramps down over 640
// - 25mV steps first 640, then 12.5mV
// - drives off while feedback above reference
// - precharged above target: drives on at end
// - power-good low in shutdown, high after start
// - power-good low on faults or disable
// - below 82% drops power-good; 85% recovers
// - soft-start trip is higher of two levels
// - release 50mV or 100mV below trip
// - overvoltage forces low gates, power-good low
// - overvoltage end resumes switching, power-good high
// - open sense shuts down, restarts soft-start
// - overcurrent comparator triggers protection
// - overcurrent: gates off 4096 cycles, retry
// - trip-retry repeats until disabled or cleared
// - shutdown holds pwm outputs high-impedance
// - start once supplies and enable valid
module sfs_sequencer #(
    parameter int OC_WAIT = sfs_pkg::OC_WAIT_TICKS
) (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        sw_tick_i,
    input  wire logic        enable_level_input_i,
    input  wire logic        vcc_por_ok_i,
    input  wire logic        pvcc_por_ok_i,
    input  wire logic        feedback_node_above_ref_i,
    input  wire logic        uv_below_i,
    input  wire logic        uv_above_i,
    input  wire logic        ov_ref_trip_i,
    input  wire logic        ov_ref_clear_i,
    input  wire logic        ov_fix_trip_i,
    input  wire logic        ov_fix_clear_i,
    input  wire logic        open_sense_i,
    input  wire logic        overcurrent_i,
    output logic      [7:0]  ref_code_o,
    output logic      [3:0]  sense_offset_o,
    output logic             pwm_hiz_o,
    output logic             gates_off_o,
    output logic             low_side_gate_force_o,
    output logic             overvoltage_guard_o,
    output logic             power_good_output_o,
    output logic             power_good_output_oe_o
);
    localparam logic [11:0] DELAY_LAST = 12'(sfs_pkg::DELAY_TICKS - 1);
    localparam logic [11:0] OC_LAST    = 12'(OC_WAIT - 1);
    localparam logic [10:0] CRS_END    = 11'(sfs_pkg::COARSE_TICKS);
    localparam logic [4:0]  CRS_LAST   = 5'(sfs_pkg::CRS_STEP_TICKS - 1);
    localparam logic [4:0]  FINE_LAST  = 5'(sfs_pkg::FINE_STEP_TICKS - 1);
    localparam logic [6:0]  OFS_LAST   = 7'(sfs_pkg::OFS_STEP_TICKS - 1);

    // two-flop synchronisers on every comparator flag
    logic [sfs_pkg::NSYNC-1:0] raw_w;
    logic [sfs_pkg::NSYNC-1:0] meta_reg;
    logic [sfs_pkg::NSYNC-1:0] sync_reg;
    assign raw_w = {enable_level_input_i, vcc_por_ok_i, pvcc_por_ok_i, feedback_node_above_ref_i,
                    uv_below_i, uv_above_i, ov_ref_trip_i, ov_ref_clear_i,
                    ov_fix_trip_i, ov_fix_clear_i, open_sense_i, overcurrent_i};
    genvar gi;
    generate
        for (gi = 0; gi < sfs_pkg::NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    meta_reg[gi] <= 1'b0;
                    sync_reg[gi] <= 1'b0;
                end else begin
                    meta_reg[gi] <= raw_w[gi];
                    sync_reg[gi] <= meta_reg[gi];
                end
            end
        end
    endgenerate

    logic en_s, vcc_s, pvcc_s, fb_above_s, uv_below_s, uv_above_s;
    logic ovr_trip_s, ovr_clr_s, ovf_trip_s, ovf_clr_s, open_s, oc_s;
    assign {en_s, vcc_s, pvcc_s, fb_above_s, uv_below_s, uv_above_s,
            ovr_trip_s, ovr_clr_s, ovf_trip_s, ovf_clr_s, open_s, oc_s} = sync_reg;

    // registers
    sfs_pkg::sfs_state_t state_reg;
    sfs_pkg::sfs_state_t state_next;
    logic        ctrl_en_reg;
    logic [7:0]  target_reg;
    logic [31:0] prdata_reg;
    logic [11:0] tick_cnt_reg;
    logic [10:0] ramp_cnt_reg;
    logic [4:0]  step_cnt_reg;
    logic [6:0]  ofs_cnt_reg;
    logic [7:0]  ref_reg;
    logic [3:0]  ofs_reg;
    logic        drv_on_reg;
    logic        uv_reg;
    logic        ov_reg;
    logic        ov_fix_reg;

    // apb decode
    wire setup_w   = psel_i && !penable_i;
    wire access_w  = psel_i && penable_i;
    wire hit_ctrl  = (paddr_i == sfs_pkg::ADDR_CTRL);
    wire hit_tgt   = (paddr_i == sfs_pkg::ADDR_TARGET);
    wire hit_stat  = (paddr_i == sfs_pkg::ADDR_STATUS);
    wire mapped_w  = hit_ctrl || hit_tgt || hit_stat;
    wire wr_w      = access_w && pwrite_i;

    assign pready_o  = 1'b1;
    assign pslverr_o = access_w && !mapped_w;
    assign prdata_o  = prdata_reg;

    logic [31:0] status_w;
    always_comb begin
        status_w = '0;
        status_w[sfs_pkg::ST_PG_BIT]    = !power_good_output_oe_o;
        status_w[sfs_pkg::ST_UV_BIT]    = uv_reg;
        status_w[sfs_pkg::ST_OV_BIT]    = ov_reg;
        status_w[sfs_pkg::ST_OVFIX_BIT] = ov_fix_reg;
        status_w[sfs_pkg::ST_DRV_BIT]   = drv_on_reg;
        status_w[sfs_pkg::ST_STATE_LSB +: 3] = state_reg;
        status_w[sfs_pkg::ST_REF_LSB +: sfs_pkg::REF_W] = ref_reg;
        status_w[sfs_pkg::ST_OFS_LSB +: 4] = ofs_reg;
    end

    wire [31:0] rd_mux_w = hit_ctrl ? {31'h0, ctrl_en_reg} :
                           hit_tgt  ? {24'h0, target_reg} :
                           hit_stat ? status_w : 32'h0;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_en_reg <= sfs_pkg::CTRL_EN_RST;
            target_reg  <= sfs_pkg::TARGET_RST;
            prdata_reg  <= 32'h0;
        end else begin
            // read data latched in setup so it stands through the zero-wait access phase
            if (setup_w && !pwrite_i) prdata_reg <= rd_mux_w;
            if (wr_w && hit_ctrl) ctrl_en_reg <= pwdata_i[sfs_pkg::CTRL_EN_BIT];
            if (wr_w && hit_tgt) target_reg <= pwdata_i[7:0];
        end
    end

    // sequencing
    wire enabled_w   = ctrl_en_reg && en_s && vcc_s && pvcc_s && !open_s;
    wire soft_w      = (state_reg == sfs_pkg::SFS_DELAY) || (state_reg == sfs_pkg::SFS_RAMP);
    wire coarse_w    = ramp_cnt_reg < CRS_END;
    wire [4:0] step_last_w = coarse_w ? CRS_LAST : FINE_LAST;
    wire [7:0] step_lsb_w  = coarse_w ? sfs_pkg::CRS_STEP_LSB : sfs_pkg::FINE_STEP_LSB;
    wire [8:0] ref_sum_w   = {1'b0, ref_reg} + {1'b0, step_lsb_w};
    wire [7:0] ref_step_w  = (ref_sum_w > {1'b0, target_reg}) ? target_reg : ref_sum_w[7:0];
    wire step_w      = sw_tick_i && (step_cnt_reg == step_last_w);
    wire ramp_done_w = ref_reg >= target_reg;
    wire oc_trip_w   = oc_s && (state_reg == sfs_pkg::SFS_RAMP || state_reg == sfs_pkg::SFS_RUN);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            sfs_pkg::SFS_SHUT:    if (enabled_w) state_next = sfs_pkg::SFS_DELAY;
            sfs_pkg::SFS_DELAY:   if (sw_tick_i && tick_cnt_reg == DELAY_LAST) state_next = sfs_pkg::SFS_RAMP;
            sfs_pkg::SFS_RAMP:    if (oc_trip_w) state_next = sfs_pkg::SFS_OC_WAIT;
                                  else if (ramp_done_w) state_next = sfs_pkg::SFS_RUN;
            sfs_pkg::SFS_RUN:     if (oc_trip_w) state_next = sfs_pkg::SFS_OC_WAIT;
            sfs_pkg::SFS_OC_WAIT: if (sw_tick_i && tick_cnt_reg == OC_LAST) state_next = sfs_pkg::SFS_DELAY;
            default:              state_next = sfs_pkg::SFS_SHUT;
        endcase
        if (!enabled_w) state_next = sfs_pkg::SFS_SHUT;
    end

    wire entering_w = state_next != state_reg;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg    <= sfs_pkg::SFS_SHUT;
            tick_cnt_reg <= 12'h000;
        end else begin
            state_reg <= state_next;
            if (entering_w) tick_cnt_reg <= 12'h000;
            else if (sw_tick_i) tick_cnt_reg <= tick_cnt_reg + 12'h001;
        end
    end

    // reference ramp and remote-sense offset
    // cleared on the way into shutdown too, so the reference is already zero there
    wire ramp_idle_w = (state_next == sfs_pkg::SFS_SHUT) ||
                       (state_reg != sfs_pkg::SFS_RAMP && state_reg != sfs_pkg::SFS_RUN);
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ramp_cnt_reg <= 11'h000;
            step_cnt_reg <= 5'h00;
            ofs_cnt_reg  <= 7'h00;
            ref_reg      <= 8'h00;
            ofs_reg      <= 4'h0;
        end else if (ramp_idle_w) begin
            ramp_cnt_reg <= 11'h000;
            step_cnt_reg <= 5'h00;
            ofs_cnt_reg  <= 7'h00;
            ref_reg      <= 8'h00;
            ofs_reg      <= sfs_pkg::OFS_INIT;
        end else if (state_reg == sfs_pkg::SFS_RUN) begin
            ref_reg <= target_reg;
            ofs_reg <= 4'h0;
        end else if (sw_tick_i) begin
            if (coarse_w) ramp_cnt_reg <= ramp_cnt_reg + 11'h001;
            step_cnt_reg <= step_w ? 5'h00 : step_cnt_reg + 5'h01;
            if (step_w) ref_reg <= ref_step_w;
            ofs_cnt_reg <= (ofs_cnt_reg == OFS_LAST) ? 7'h00 : ofs_cnt_reg + 7'h01;
            if (ofs_cnt_reg == OFS_LAST && ofs_reg != 4'h0) ofs_reg <= ofs_reg - 4'h1;
        end
    end

    // drives, voltage monitors
    wire ov_trip_w = soft_w ? (ovr_trip_s && ovf_trip_s) : ovr_trip_s;
    wire ov_fix_w  = soft_w && (ref_reg < sfs_pkg::OV_FIX_REF_CODE);
    wire ov_clr_w  = ov_fix_reg ? ovf_clr_s : ovr_clr_s;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            drv_on_reg <= 1'b0;
            uv_reg     <= 1'b0;
            ov_reg     <= 1'b0;
            ov_fix_reg <= 1'b0;
        end else begin
            if (state_reg == sfs_pkg::SFS_RAMP && !fb_above_s) drv_on_reg <= 1'b1;
            else if (state_reg == sfs_pkg::SFS_RUN) drv_on_reg <= 1'b1;
            else if (state_reg != sfs_pkg::SFS_RAMP) drv_on_reg <= 1'b0;
            if (state_reg != sfs_pkg::SFS_RUN) uv_reg <= 1'b0;
            else if (uv_below_s) uv_reg <= 1'b1;
            else if (uv_above_s) uv_reg <= 1'b0;
            if (state_reg == sfs_pkg::SFS_SHUT) ov_reg <= 1'b0;
            else if (!ov_reg && ov_trip_w) begin
                ov_reg     <= 1'b1;
                ov_fix_reg <= ov_fix_w;
            end else if (ov_reg && ov_clr_w) ov_reg <= 1'b0;
        end
    end

    // pg is released only from a completed start with no voltage fault
    wire pg_ok_w = (state_reg == sfs_pkg::SFS_RUN) && !uv_reg && !ov_reg;

    assign ref_code_o             = ref_reg;
    assign sense_offset_o         = ofs_reg;
    // drv_on_reg lags a drop out of run by one cycle, shutdown forces high-impedance at once
    assign pwm_hiz_o              = !drv_on_reg || state_reg == sfs_pkg::SFS_OC_WAIT
                                    || state_reg == sfs_pkg::SFS_SHUT;
    assign gates_off_o            = state_reg == sfs_pkg::SFS_OC_WAIT;
    assign low_side_gate_force_o  = ov_reg;
    assign overvoltage_guard_o    = ov_reg;
    assign power_good_output_o    = 1'b0;
    assign power_good_output_oe_o = !pg_ok_w;

    // checks
    sequence s_oc_hit;
        oc_s && (state_reg == sfs_pkg::SFS_RUN) && enabled_w;
    endsequence
    sequence s_oc_held;
        gates_off_o && pwm_hiz_o && power_good_output_oe_o;
    endsequence

    property p_delay_end;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_reg == sfs_pkg::SFS_DELAY && sw_tick_i && tick_cnt_reg == DELAY_LAST && enabled_w)
            |=> state_reg == sfs_pkg::SFS_RAMP;
    endproperty
    a_delay_end: assert property (p_delay_end) else $error("delay did not end after 64 ticks");

    property p_shut_off;
        @(posedge clk_i) disable iff (!nrst_i)
        state_reg == sfs_pkg::SFS_SHUT |-> pwm_hiz_o && power_good_output_oe_o && ref_reg == 8'h00;
    endproperty
    a_shut_off: assert property (p_shut_off) else $error("shutdown not quiet");

    property p_oc_entry;
        @(posedge clk_i) disable iff (!nrst_i)
        s_oc_hit |=> s_oc_held ##1 (s_oc_held or !enabled_w);
    endproperty
    a_oc_entry: assert property (p_oc_entry) else $error("overcurrent did not turn gates off");

    property p_ov_force;
        @(posedge clk_i) disable iff (!nrst_i)
        (!ov_reg && ov_trip_w && state_reg != sfs_pkg::SFS_SHUT) |=> low_side_gate_force_o && power_good_output_oe_o;
    endproperty
    a_ov_force: assert property (p_ov_force) else $error("overvoltage onset not acted on");

    property p_pg_only_run;
        @(posedge clk_i) disable iff (!nrst_i)
        !power_good_output_oe_o |-> state_reg == sfs_pkg::SFS_RUN && $past(state_reg) != sfs_pkg::SFS_SHUT;
    endproperty
    a_pg_only_run: assert property (p_pg_only_run) else $error("power-good released outside run");

    property p_uv_pg;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_reg == sfs_pkg::SFS_RUN && uv_below_s) |=> power_good_output_oe_o;
    endproperty
    a_uv_pg: assert property (p_uv_pg) else $error("undervoltage left power-good high");

    property p_ofs_zero;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_reg == sfs_pkg::SFS_RAMP && !coarse_w) |-> ofs_reg == 4'h0;
    endproperty
    a_ofs_zero: assert property (p_ofs_zero) else $error("sense offset not zero after 640 ticks");

    property p_ref_step;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_reg == sfs_pkg::SFS_RAMP && ref_reg > $past(ref_reg))
            |-> (ref_reg - $past(ref_reg)) <= ($past(coarse_w) ? sfs_pkg::CRS_STEP_LSB : sfs_pkg::FINE_STEP_LSB);
    endproperty
    a_ref_step: assert property (p_ref_step) else $error("reference step too large");

    property p_disable;
        @(posedge clk_i) disable iff (!nrst_i)
        !enabled_w |=> state_reg == sfs_pkg::SFS_SHUT ##1 power_good_output_oe_o;
    endproperty
    a_disable: assert property (p_disable) else $error("disable did not shut down");

    property p_delay_hold;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_reg == sfs_pkg::SFS_DELAY && enabled_w && !(sw_tick_i && tick_cnt_reg == DELAY_LAST))
            |=> state_reg == sfs_pkg::SFS_DELAY;
    endproperty
    a_delay_hold: assert property (p_delay_hold) else $error("delay ended early");

    property p_drv_hold;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_reg == sfs_pkg::SFS_RAMP && fb_above_s && !drv_on_reg) |=> pwm_hiz_o;
    endproperty
    a_drv_hold: assert property (p_drv_hold) else $error("drives enabled while feedback above reference");

    property p_ov_hold;
        @(posedge clk_i) disable iff (!nrst_i)
        (ov_reg && !ov_clr_w && state_reg != sfs_pkg::SFS_SHUT)
            |=> low_side_gate_force_o && power_good_output_oe_o;
    endproperty
    a_ov_hold: assert property (p_ov_hold) else $error("low-side force dropped before release");

    property p_oc_retry;
        @(posedge clk_i) disable iff (!nrst_i)
        (gates_off_o && sw_tick_i && tick_cnt_reg == OC_LAST && enabled_w) |=> state_reg == sfs_pkg::SFS_DELAY;
    endproperty
    a_oc_retry: assert property (p_oc_retry) else $error("no new soft-start after overcurrent wait");

    property p_run_drive;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_reg == sfs_pkg::SFS_RUN && $past(state_reg) == sfs_pkg::SFS_RUN) |-> !pwm_hiz_o;
    endproperty
    a_run_drive: assert property (p_run_drive) else $error("drives still off in run");
endmodule

// >>> verilog/sfs_pkg.sv
package sfs_pkg;
    // apb map, byte addresses
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_TARGET     = 8'h04;
    localparam logic [7:0]  ADDR_STATUS     = 8'h08;

    // control fields
    localparam int          CTRL_EN_BIT     = 0;
    localparam logic        CTRL_EN_RST     = 1'b0;

    // reference codes use a 12.5 mV step
    localparam int          REF_W           = 8;
    localparam logic [7:0]  TARGET_RST      = 8'h60;   // 1.2 V
    localparam logic [7:0]  LSB_PER_VOLT    = 8'h50;   // 80 steps of 12.5 mV
    // ref+150mV rises above the fixed 1.67 V level from 1.525 V upward
    localparam logic [7:0]  OV_FIX_REF_CODE = 8'h7A;

    // status fields
    localparam int          ST_PG_BIT       = 0;
    localparam int          ST_UV_BIT       = 1;
    localparam int          ST_OV_BIT       = 2;
    localparam int          ST_OVFIX_BIT    = 3;
    localparam int          ST_DRV_BIT      = 4;
    localparam int          ST_STATE_LSB    = 8;
    localparam int          ST_REF_LSB      = 16;
    localparam int          ST_OFS_LSB      = 24;

    // timing in switching cycles
    localparam int          DELAY_TICKS     = 64;
    localparam int          TICKS_PER_VOLT  = 1280;
    localparam int          COARSE_TICKS    = 640;
    localparam int          FINE_STEP_TICKS = TICKS_PER_VOLT / 80;
    localparam int          CRS_STEP_TICKS  = 2 * FINE_STEP_TICKS;
    localparam logic [7:0]  CRS_STEP_LSB    = 8'h02;   // 25 mV
    localparam logic [7:0]  FINE_STEP_LSB   = 8'h01;   // 12.5 mV
    localparam logic [3:0]  OFS_INIT        = 4'h8;    // 100 mV
    localparam int          OFS_STEP_TICKS  = COARSE_TICKS / 8;
    localparam int          OC_WAIT_TICKS   = 4096;

    localparam int          NSYNC           = 12;

    typedef enum logic [2:0] {
        SFS_SHUT,
        SFS_DELAY,
        SFS_RAMP,
        SFS_RUN,
        SFS_OC_WAIT
    } sfs_state_t;
endpackage

// >>> test/sfs_stage_model.sv
`timescale 1ns/1ns
module sfs_stage_model (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic [7:0] ref_code_i,
    input  wire logic [7:0] precharge_i,
    output logic            sw_tick_o,
    output logic            fb_above_o
);
    // a tick every other clock keeps soft-start short while still spacing ticks apart
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sw_tick_o <= 1'b0;
        end else begin
            sw_tick_o <= !sw_tick_o;
        end
    end
    // output stays at its precharge level until the ramping reference passes it
    assign fb_above_o = (ref_code_i < precharge_i);
endmodule

// >>> test/tb_sfs_sequencer.sv
`timescale 1ns/1ns
module tb_sfs_sequencer;
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr, tick, fb;
    logic [7:0]  paddr, ref_code, pre;
    logic [31:0] pwdata, prdata, rd;
    logic        en, uvb, uva, ovrt, ovrc, osense, oc, goff, lsf, ovg, pg, pgoe, hiz, er, ovft, ovfc;
    logic [3:0]  ofs;
    int          num_errors = 0;
    int          n_compared = 0;
    // high enough that the ramp runs past the coarse part into fine steps
    localparam logic [7:0] TGT = 8'h30;

    sfs_stage_model stage_u (.clk_i(clk), .nrst_i(nrst), .ref_code_i(ref_code), .precharge_i(pre),
        .sw_tick_o(tick), .fb_above_o(fb));
    sfs_sequencer #(.OC_WAIT(8)) dut_u (.clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .sw_tick_i(tick), .enable_level_input_i(en), .vcc_por_ok_i(1'b1),
        .pvcc_por_ok_i(1'b1), .feedback_node_above_ref_i(fb), .uv_below_i(uvb), .uv_above_i(uva),
        .ov_ref_trip_i(ovrt), .ov_ref_clear_i(ovrc), .ov_fix_trip_i(ovft), .ov_fix_clear_i(ovfc),
        .open_sense_i(osense), .overcurrent_i(oc), .ref_code_o(ref_code), .sense_offset_o(ofs),
        .pwm_hiz_o(hiz), .gates_off_o(goff), .low_side_gate_force_o(lsf), .overvoltage_guard_o(ovg),
        .power_good_output_o(pg), .power_good_output_oe_o(pgoe));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // sel: 0 pg pull-down, 1 pwm hiz, 2 gates off, 3 low-side force
    task automatic wait_on(input int sel, input logic val, input int lim);
        logic s;
        for (int i = 0; i < lim; i++) begin
            @(negedge clk);
            case (sel)
                0: s = pgoe;
                1: s = hiz;
                2: s = goff;
                default: s = lsf;
            endcase
            if (s === val) return;
        end
        num_errors++;
        $display("[ERR] t=%0t wait sel=%h val=%h", $time, sel, val);
        final_report();
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            num_errors++;
            $display("[ERR] t=%0t apb %h %h", $time, a, 8'h00);
            final_report();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic t_regs();
        @(negedge clk);
        chk(pgoe, 1'b1);
        chk(hiz, 1'b1);
        apb(1'b0, sfs_pkg::ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, sfs_pkg::ADDR_TARGET, 32'h0);
        chk(rd, 32'h60);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, sfs_pkg::ADDR_TARGET, {24'h0, TGT});
        apb(1'b1, sfs_pkg::ADDR_CTRL, 32'h1);
        repeat (20) @(negedge clk);
        chk(hiz, 1'b1);
        $display("done registers");
    endtask

    // p is the precharged output level in reference codes
    task automatic t_start(input logic [7:0] p);
        int ticks = 0;
        logic [7:0] ron = 8'hFF;
        logic [3:0] ofs_fine = 4'hF;
        @(posedge clk);
        pre <= p;
        en <= 1'b1;
        repeat (6) @(negedge clk);
        chk(ofs, sfs_pkg::OFS_INIT);
        while (ref_code < TGT && ticks < 1000) begin
            @(negedge clk);
            if (tick === 1'b1) ticks++;
            if (hiz === 1'b0 && ron === 8'hFF) ron = ref_code;
            // an odd code only shows up once single fine steps have begun
            if (ref_code == 8'h29 && ofs_fine === 4'hF) ofs_fine = ofs;
        end
        chk(ticks >= 64 + 16 * TGT - 2 && ticks <= 64 + 16 * TGT + 4, 1'b1);
        chk(ofs_fine, 4'h0);
        if (p < TGT) begin
            chk(ron, p);
        end else begin
            chk(ron, 8'hFF);
        end
        wait_on(1, 1'b0, 8);
        wait_on(0, 1'b0, 8);
        chk(pg, 1'b0);
        apb(1'b0, sfs_pkg::ADDR_STATUS, 32'h0);
        chk(rd[10:8], 3'h3);
        $display("done soft-start");
    endtask

    task automatic t_uv();
        @(posedge clk);
        uvb <= 1'b1;
        uva <= 1'b0;
        wait_on(0, 1'b1, 8);
        chk({hiz, lsf, goff}, 3'h0);
        @(posedge clk);
        uvb <= 1'b0;
        repeat (8) @(negedge clk);
        chk(pgoe, 1'b1);
        @(posedge clk);
        uva <= 1'b1;
        wait_on(0, 1'b0, 8);
        $display("done undervoltage");
    endtask

    task automatic t_ov();
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            ovrt <= 1'b1;
            ovrc <= 1'b0;
            wait_on(3, 1'b1, 8);
            chk({pgoe, ovg}, 2'h3);
            @(posedge clk);
            ovrt <= 1'b0;
            repeat (8) @(negedge clk);
            chk(lsf, 1'b1);
            @(posedge clk);
            ovrc <= 1'b1;
            wait_on(3, 1'b0, 8);
            wait_on(0, 1'b0, 8);
            chk(hiz, 1'b0);
        end
        $display("done overvoltage");
    endtask

    task automatic t_oc();
        int ticks = 0;
        @(posedge clk);
        oc <= 1'b1;
        wait_on(2, 1'b1, 8);
        chk({pgoe, hiz}, 2'h3);
        while (goff === 1'b1 && ticks < 100) begin
            @(negedge clk);
            if (tick === 1'b1) ticks++;
        end
        chk(ticks >= 7 && ticks <= 9, 1'b1);
        wait_on(2, 1'b1, 1000);
        @(posedge clk);
        oc <= 1'b0;
        wait_on(2, 1'b0, 100);
        wait_on(0, 1'b0, 2000);
        chk(lsf, 1'b0);
        $display("done overcurrent");
    endtask

    task automatic t_open();
        @(posedge clk);
        osense <= 1'b1;
        wait_on(1, 1'b1, 8);
        chk(pgoe, 1'b1);
        @(posedge clk);
        osense <= 1'b0;
        wait_on(1, 1'b0, 1000);
        wait_on(0, 1'b0, 2000);
        $display("done open sense");
    endtask

    // overvoltage during the start delay, where the fixed level is the higher one
    task automatic t_ov_soft();
        @(posedge clk);
        en <= 1'b1;
        repeat (6) @(negedge clk);
        @(posedge clk);
        ovrt <= 1'b1;
        ovrc <= 1'b0;
        repeat (8) @(negedge clk);
        chk(lsf, 1'b0);
        @(posedge clk);
        ovft <= 1'b1;
        ovfc <= 1'b0;
        wait_on(3, 1'b1, 8);
        apb(1'b0, sfs_pkg::ADDR_STATUS, 32'h0);
        chk(rd[3:2], 2'h3);
        @(posedge clk);
        ovrt <= 1'b0;
        ovft <= 1'b0;
        ovrc <= 1'b1;
        repeat (8) @(negedge clk);
        chk(lsf, 1'b1);
        @(posedge clk);
        ovfc <= 1'b1;
        wait_on(3, 1'b0, 8);
        chk(ovg, 1'b0);
        $display("done soft-start overvoltage");
    endtask

    task automatic t_off();
        @(posedge clk);
        en <= 1'b0;
        wait_on(0, 1'b1, 8);
        chk(hiz, 1'b1);
        repeat (4) @(negedge clk);
        $display("done disable");
    endtask

    initial begin
        nrst = 1'b0;
        {psel, penable, pwrite, en, uvb, ovrt, ovft, osense, oc} = 9'h000;
        {uva, ovrc, ovfc} = 3'h7;
        paddr = 8'h00;
        pwdata = 32'h0;
        pre = 8'h00;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_start(8'h04);
        t_uv();
        t_ov();
        t_oc();
        t_open();
        t_off();
        t_ov_soft();
        t_off();
        t_start(8'hFF);
        t_off();
        final_report();
    end
endmodule
